// *** hdl/drs_pkg.sv ***
// Shared constants and types for the dual instruction-set register state map.
// Assumes a single pclk domain and an APB master with 32-bit data.
package drs_pkg;

  // ----------------------------------------------------------------
  // Register file geometry
  // ----------------------------------------------------------------
  localparam int REG_COUNT = 128;
  localparam logic [6:0] GR_ZERO = 7'h00;
  localparam logic [6:0] GR_LEGACY_GP = 7'h08;
  localparam logic [6:0] GR_SELECTORS = 7'h10;
  localparam logic [6:0] GR_DESC_EXTRA = 7'h18;
  localparam logic [6:0] GR_DESC_DATA = 7'h1B;
  localparam logic [6:0] GR_DESC_GLOBAL = 7'h1F;
  localparam logic [6:0] FR_LEGACY_FP = 7'h08;
  localparam logic [6:0] FR_VECTOR = 7'h10;
  localparam int DESC_PRESENT_BIT = 47;

  // ----------------------------------------------------------------
  // Legacy register identifiers seen by the legacy decoder
  // ----------------------------------------------------------------
  localparam logic [5:0] LID_GP = 6'h00;
  localparam logic [5:0] LID_SEL = 6'h08;
  localparam logic [5:0] LID_DESC = 6'h10;
  localparam logic [5:0] LID_DESC_END = 6'h16;
  localparam logic [5:0] LID_FP = 6'h18;
  localparam logic [5:0] LID_VEC = 6'h20;
  localparam logic [5:0] LID_END = 6'h30;
  localparam logic [1:0] WID_16 = 2'h0;
  localparam logic [1:0] WID_32 = 2'h1;
  localparam logic [1:0] WID_64 = 2'h2;

  // ----------------------------------------------------------------
  // Legacy operating modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_REAL = 2'h0;
  localparam logic [1:0] MODE_V86 = 2'h1;
  localparam logic [1:0] MODE_PROT = 2'h2;

  // ----------------------------------------------------------------
  // APB map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_INDEX = 12'h008;
  localparam logic [11:0] OFS_DATA_LO = 12'h00C;
  localparam logic [11:0] OFS_DATA_HI = 12'h010;
  localparam logic [11:0] OFS_IP_LO = 12'h014;
  localparam logic [11:0] OFS_IP_HI = 12'h018;
  localparam int CTRL_XFER_EN_BIT = 0;
  localparam logic CTRL_XFER_EN_RST = 1'b1;
  localparam int STATUS_LEGACY_BIT = 0;
  localparam int STATUS_MODE_LSB = 1;
  localparam int STATUS_CHK_ERR_BIT = 3;
  localparam int INDEX_FR_BIT = 8;

  typedef enum logic [1:0] {
    DRS_ST_NATIVE = 2'b01,
    DRS_ST_LEGACY = 2'b10
  } drs_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic legacy;
    logic is_fr;
    logic [6:0] idx;
    logic [5:0] legacy_id;
    logic [63:0] wdata;
  } drs_ex_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [63:0] rdata;
  } drs_ex_rsp_t;

  typedef struct packed {
    logic jump_native;
    logic interrupt;
    logic to_legacy;
    logic [1:0] target_mode;
    logic [63:0] target_ip;
  } drs_xfer_t;

  typedef struct packed {
    logic valid;
    logic is_fr;
    logic [6:0] idx;
    logic [5:0] lsb;
    logic [1:0] width;
  } drs_map_t;

  typedef struct packed {
    drs_state_t state;
    logic [1:0] submode;
    logic xfer_en;
    logic chk_err;
    logic refused;
    logic idx_fr;
    logic [6:0] idx;
    logic [31:0] data_lo;
    logic [63:0] ip;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    drs_ex_rsp_t rsp;
  } drs_regs_t;

endpackage

// *** hdl/drs_legacy_map.sv ***
// Translates a legacy register identifier into its home in the native files.
// Pure combinational; the instantiating module registers whatever it needs.
`timescale 1ns/1ps
module drs_legacy_map (
  input wire logic [5:0] legacy_id, // Legacy register identifier
  output drs_pkg::drs_map_t map // Native location of that register
);

  logic [5:0] ofs;

  always_comb begin
    map = '0;
    ofs = 6'h00;
    if (legacy_id < drs_pkg::LID_SEL) begin
      map.valid = 1'b1;
      map.idx = drs_pkg::GR_LEGACY_GP + {4'h0, legacy_id[2:0]};
      map.width = drs_pkg::WID_32;
    end else if (legacy_id < drs_pkg::LID_DESC) begin
      ofs = legacy_id - drs_pkg::LID_SEL;
      map.valid = 1'b1;
      map.idx = drs_pkg::GR_SELECTORS + {6'h00, ofs[2]};
      map.lsb = {ofs[1:0], 4'h0};
      map.width = drs_pkg::WID_16;
    end else if (legacy_id < drs_pkg::LID_DESC_END) begin
      ofs = legacy_id - drs_pkg::LID_DESC;
      map.valid = 1'b1;
      // The extra segment sits apart from the other five descriptors.
      map.idx = (ofs == 6'h00) ? drs_pkg::GR_DESC_EXTRA : drs_pkg::GR_DESC_DATA + {1'b0, ofs} - 7'h01;
      map.width = drs_pkg::WID_64;
    end else if (legacy_id >= drs_pkg::LID_FP && legacy_id < drs_pkg::LID_VEC) begin
      map.valid = 1'b1;
      map.is_fr = 1'b1;
      map.idx = drs_pkg::FR_LEGACY_FP + {4'h0, legacy_id[2:0]};
      map.width = drs_pkg::WID_64;
    end else if (legacy_id >= drs_pkg::LID_VEC && legacy_id < drs_pkg::LID_END) begin
      ofs = legacy_id - drs_pkg::LID_VEC;
      map.valid = 1'b1;
      map.is_fr = 1'b1;
      // Even identifier is the low half, odd the high half of one vector.
      map.idx = drs_pkg::FR_VECTOR + {3'h0, ofs[3:0]};
      map.width = drs_pkg::WID_64;
    end
  end

endmodule

// *** hdl/drs_top.sv ***
// Register state map shared by the native and legacy instruction sets.
// Assumes the decode/execute logic drives requests synchronous to pclk.
`timescale 1ns/1ps

// How it works
// - Jump-to-native or any interruption moves every legacy mode to native mode.
// - Native mode may branch into real, virtual-8086 or protected legacy mode.
// - Entry to legacy mode checks data and global descriptors are present.
// - Legacy registers live in general registers 8-31, 32-bit values low.
// - Legacy float, multimedia and vector state live in float registers 8-31.
// - Data pass between instruction sets bit for bit, unconverted.
// - Native code reaches everything; legacy code only legacy-visible state.
// - Legacy execution changes only legacy-class and scratch native registers.
// - Legacy-class registers hold legacy values in legacy mode, anything otherwise.
// - Modified-class registers serve as scratch while legacy code runs.
// - Unmodified-class registers are identical before and after legacy execution.
// - The stack pointer is one value shared by both sets.
// - One shared 64-bit instruction pointer serves both instruction sets.
// - General registers 8-15 hold the eight legacy 32-bit registers in order.
// - Registers 24 and 27-31 each hold one 64-bit segment descriptor.
// - General registers 1-3, 18-23, 25-26 are legacy scratch.
// - General 4-7 and float 2-5 stay unchanged during legacy execution.
// - General 32-127 and float 6-7 are legacy working space.
// - Each 128-bit vector takes an even/odd float pair, low half even.
module drs_top (
  input wire logic pclk, // 20 MHz clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped offsets
  input drs_pkg::drs_ex_req_t ex_req, // Register access from execution logic
  output drs_pkg::drs_ex_rsp_t ex_rsp, // Answer one cycle after the request
  input drs_pkg::drs_xfer_t xfer, // Instruction-set transition events
  input wire logic ip_we, // Execution logic updates the pointer
  input wire logic [63:0] ip_wdata, // New instruction pointer value
  output logic legacy_active, // High while legacy instructions run
  output logic [1:0] legacy_mode, // Legacy operating mode
  output logic [63:0] ip, // Shared instruction pointer
  output logic xfer_refused // Pulse: a transition was refused
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [63:0] gr_mem [drs_pkg::REG_COUNT];
  logic [63:0] fr_mem [drs_pkg::REG_COUNT];
  drs_pkg::drs_regs_t r_q;
  drs_pkg::drs_regs_t r_d;
  drs_pkg::drs_map_t lmap;
  logic mem_we;
  logic mem_fr;
  logic [6:0] mem_idx;
  logic [63:0] mem_wdata;

  drs_legacy_map u_map (
    .legacy_id(ex_req.legacy_id),
    .map(lmap)
  );

  // Scratch classes of the general and float files.
  function automatic logic is_scratch(input logic fr, input logic [6:0] idx);
    logic s;
    s = 1'b0;
    if (fr) begin
      s = (idx == 7'h06) || (idx == 7'h07) || (idx >= 7'h20);
    end else begin
      s = (idx >= 7'h01 && idx <= 7'h03) || (idx >= 7'h12 && idx <= 7'h17) ||
          (idx == 7'h19) || (idx == 7'h1A) || (idx >= 7'h20);
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Access path
  // ----------------------------------------------------------------
  logic tgt_fr;
  logic [6:0] tgt_idx;
  logic [5:0] tgt_lsb;
  logic [63:0] wmask;
  logic [63:0] cur;
  logic [63:0] merged;
  logic access_ok;
  logic in_legacy;
  logic desc_ok;
  logic apb_commit;
  logic [63:0] sel_word;
  // Marks a descriptor failure in this cycle, so that a clear in the same cycle cannot hide it.
  logic chk_set;

  always_comb begin
    in_legacy = (r_q.state == drs_pkg::DRS_ST_LEGACY);
    tgt_fr = ex_req.legacy ? lmap.is_fr : ex_req.is_fr;
    tgt_idx = ex_req.legacy ? lmap.idx : ex_req.idx;
    tgt_lsb = ex_req.legacy ? lmap.lsb : 6'h00;
    wmask = 64'hFFFFFFFFFFFFFFFF;
    if (ex_req.legacy && lmap.width == drs_pkg::WID_16) begin
      wmask = 64'h000000000000FFFF << tgt_lsb;
    end else if (ex_req.legacy && lmap.width == drs_pkg::WID_32) begin
      wmask = 64'h00000000FFFFFFFF;
    end
    cur = tgt_fr ? fr_mem[tgt_idx] : gr_mem[tgt_idx];
    // Raw bits are merged; no format conversion ever happens here.
    merged = (cur & ~wmask) | ((ex_req.wdata << tgt_lsb) & wmask);
    if (ex_req.legacy) begin
      access_ok = lmap.valid;
    end else if (in_legacy) begin
      // Native indices during legacy execution reach scratch only.
      access_ok = is_scratch(tgt_fr, tgt_idx);
    end else begin
      access_ok = 1'b1;
    end
    desc_ok = gr_mem[drs_pkg::GR_DESC_DATA][drs_pkg::DESC_PRESENT_BIT] &
              gr_mem[drs_pkg::GR_DESC_GLOBAL][drs_pkg::DESC_PRESENT_BIT];
    sel_word = r_q.idx_fr ? fr_mem[r_q.idx] : gr_mem[r_q.idx];
    apb_commit = psel && penable && r_q.pready && pwrite && (paddr == drs_pkg::OFS_DATA_HI);
  end

  // The bus window commit wins a same-cycle collision; the execution
  // write is then answered with an error rather than silently lost.
  always_comb begin
    mem_we = 1'b0;
    mem_fr = tgt_fr;
    mem_idx = tgt_idx;
    mem_wdata = merged;
    if (apb_commit) begin
      mem_we = 1'b1;
      mem_fr = r_q.idx_fr;
      mem_idx = r_q.idx;
      mem_wdata = {pwdata, r_q.data_lo};
    end else if (ex_req.valid && ex_req.write && access_ok) begin
      mem_we = 1'b1;
    end
  end

  always_ff @(posedge pclk) begin
    if (mem_we && !(!mem_fr && mem_idx == drs_pkg::GR_ZERO)) begin
      if (mem_fr) begin
        fr_mem[mem_idx] <= mem_wdata;
      end else begin
        gr_mem[mem_idx] <= mem_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.refused = 1'b0;
    r_d.rsp = '0;
    r_d.pready = 1'b0;
    r_d.pslverr = 1'b0;
    chk_set = 1'b0;
    if (ex_req.valid) begin
      r_d.rsp.valid = 1'b1;
      r_d.rsp.err = !access_ok || (ex_req.write && apb_commit);
      if (access_ok && !ex_req.write) begin
        if (!tgt_fr && tgt_idx == drs_pkg::GR_ZERO) begin
          r_d.rsp.rdata = 64'h0000000000000000;
        end else begin
          r_d.rsp.rdata = (cur & wmask) >> tgt_lsb;
        end
      end
    end
    if (ip_we) begin
      r_d.ip = ip_wdata;
    end
    if (in_legacy) begin
      if (xfer.interrupt || (xfer.jump_native && r_q.xfer_en)) begin
        r_d.state = drs_pkg::DRS_ST_NATIVE;
        r_d.ip = xfer.target_ip;
      end else if (xfer.jump_native) begin
        r_d.refused = 1'b1;
      end
    end else if (xfer.to_legacy) begin
      // Descriptors must have been loaded by native code beforehand.
      if (r_q.xfer_en && desc_ok && xfer.target_mode <= drs_pkg::MODE_PROT) begin
        r_d.state = drs_pkg::DRS_ST_LEGACY;
        r_d.submode = xfer.target_mode;
        r_d.ip = {32'h00000000, xfer.target_ip[31:0]};
      end else begin
        r_d.refused = 1'b1;
        if (!desc_ok) begin
          r_d.chk_err = 1'b1;
          chk_set = 1'b1;
        end
      end
    end
    if (psel && !penable) begin
      r_d.pready = 1'b1;
      r_d.prdata = 32'h00000000;
      if (paddr == drs_pkg::OFS_CTRL) begin
        r_d.prdata[drs_pkg::CTRL_XFER_EN_BIT] = r_q.xfer_en;
      end else if (paddr == drs_pkg::OFS_STATUS) begin
        r_d.prdata[drs_pkg::STATUS_LEGACY_BIT] = in_legacy;
        r_d.prdata[drs_pkg::STATUS_MODE_LSB +: 2] = r_q.submode;
        r_d.prdata[drs_pkg::STATUS_CHK_ERR_BIT] = r_q.chk_err;
      end else if (paddr == drs_pkg::OFS_INDEX) begin
        r_d.prdata[drs_pkg::INDEX_FR_BIT] = r_q.idx_fr;
        r_d.prdata[6:0] = r_q.idx;
      end else if (paddr == drs_pkg::OFS_DATA_LO) begin
        r_d.prdata = sel_word[31:0];
      end else if (paddr == drs_pkg::OFS_DATA_HI) begin
        r_d.prdata = sel_word[63:32];
      end else if (paddr == drs_pkg::OFS_IP_LO) begin
        r_d.prdata = r_q.ip[31:0];
      end else if (paddr == drs_pkg::OFS_IP_HI) begin
        r_d.prdata = r_q.ip[63:32];
      end else begin
        r_d.pslverr = 1'b1;
      end
    end
    if (psel && penable && r_q.pready && pwrite && !r_q.pslverr) begin
      if (paddr == drs_pkg::OFS_CTRL) begin
        r_d.xfer_en = pwdata[drs_pkg::CTRL_XFER_EN_BIT];
      end else if (paddr == drs_pkg::OFS_STATUS) begin
        // Write one to clear; a check failure in this cycle still sets it.
        if (pwdata[drs_pkg::STATUS_CHK_ERR_BIT] && !chk_set) begin
          r_d.chk_err = 1'b0;
        end
      end else if (paddr == drs_pkg::OFS_INDEX) begin
        r_d.idx_fr = pwdata[drs_pkg::INDEX_FR_BIT];
        r_d.idx = pwdata[6:0];
      end else if (paddr == drs_pkg::OFS_DATA_LO) begin
        r_d.data_lo = pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '{state: drs_pkg::DRS_ST_NATIVE, submode: drs_pkg::MODE_REAL,
               xfer_en: drs_pkg::CTRL_XFER_EN_RST, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign ex_rsp = r_q.rsp;
  assign legacy_active = (r_q.state == drs_pkg::DRS_ST_LEGACY);
  assign legacy_mode = r_q.submode;
  assign ip = r_q.ip;
  assign xfer_refused = r_q.refused;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_jump_to_native: assert property (
    in_legacy && xfer.jump_native && r_q.xfer_en |=> !legacy_active && ip == $past(xfer.target_ip))
    else $error("jump to native did not leave legacy mode");
  a_interrupt_to_native: assert property (
    in_legacy && xfer.interrupt |=> !legacy_active)
    else $error("interruption did not return to native mode");
  a_legacy_entry_ok: assert property (
    !in_legacy && xfer.to_legacy && r_q.xfer_en && desc_ok && xfer.target_mode == drs_pkg::MODE_V86
    |=> legacy_active && legacy_mode == drs_pkg::MODE_V86)
    else $error("legacy entry not taken");
  a_desc_refuse: assert property (
    !in_legacy && xfer.to_legacy && !desc_ok |=> !legacy_active && xfer_refused ##1 !xfer_refused)
    else $error("inconsistent descriptors not refused");
  a_ip_upper_zero: assert property (
    $rose(legacy_active) |-> ip[63:32] == 32'h00000000)
    else $error("pointer not truncated on legacy entry");
  a_preserved_write: assert property (
    in_legacy && ex_req.valid && ex_req.write && !ex_req.legacy && !ex_req.is_fr &&
    ex_req.idx >= 7'h04 && ex_req.idx <= 7'h07 |=> ex_rsp.valid && ex_rsp.err)
    else $error("preserved register written in legacy mode");
  a_scratch_write: assert property (
    in_legacy && ex_req.valid && ex_req.write && !ex_req.legacy && !ex_req.is_fr &&
    ex_req.idx >= 7'h12 && ex_req.idx <= 7'h17 && !apb_commit |=> ex_rsp.valid && !ex_rsp.err)
    else $error("scratch register refused in legacy mode");
  a_gp_map: assert property (
    ex_req.legacy_id < drs_pkg::LID_SEL |-> !lmap.is_fr && lmap.idx == 7'h08 + {4'h0, ex_req.legacy_id[2:0]})
    else $error("legacy general register misplaced");
  a_sel_pack: assert property (
    ex_req.legacy_id == 6'h0D |-> lmap.idx == 7'h11 && lmap.lsb == 6'h10)
    else $error("selector packing wrong");
  a_vector_half: assert property (
    ex_req.legacy_id == 6'h21 |-> lmap.is_fr && lmap.idx == 7'h11)
    else $error("vector half misplaced");
  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not one cycle");

  a_refuse_jump: assert property (
    in_legacy && xfer.jump_native && !xfer.interrupt && !r_q.xfer_en
    |=> legacy_active && xfer_refused)
    else $error("disabled jump was not refused");
  a_zero_reads_zero: assert property (
    ex_req.valid && !ex_req.write && !ex_req.legacy && !ex_req.is_fr && ex_req.idx == drs_pkg::GR_ZERO
    |=> ex_rsp.valid && ex_rsp.rdata == 64'h0000000000000000)
    else $error("register zero not read as zero");
  a_desc_map: assert property (
    ex_req.legacy_id == drs_pkg::LID_DESC
    |-> !lmap.is_fr && lmap.idx == 7'h18 && lmap.width == drs_pkg::WID_64)
    else $error("extra descriptor misplaced");
  a_ip_update: assert property (
    ip_we && !xfer.jump_native && !xfer.interrupt && !xfer.to_legacy
    |=> ip == $past(ip_wdata))
    else $error("pointer update lost");
  a_legacy_32bit: assert property (
    ex_req.valid && ex_req.legacy && ex_req.legacy_id < drs_pkg::LID_SEL && !ex_req.write
    |=> ex_rsp.rdata[63:32] == 32'h00000000)
    else $error("legacy register read wider than 32 bits");
  a_float_preserved: assert property (
    in_legacy && ex_req.valid && !ex_req.legacy && ex_req.is_fr &&
    ex_req.idx >= 7'h02 && ex_req.idx <= 7'h05 |=> ex_rsp.err)
    else $error("preserved float register reached in legacy mode");
  a_chk_sticky: assert property (
    chk_set |=> r_q.chk_err)
    else $error("check failure not recorded");

  c_legacy_entry: cover property ($rose(legacy_active));
  c_interrupt_exit: cover property (in_legacy && xfer.interrupt ##1 !legacy_active);
  c_refused: cover property (xfer_refused);
  c_window_commit: cover property (apb_commit);
  c_jump_exit: cover property (in_legacy && xfer.jump_native && r_q.xfer_en);

endmodule

// *** verification/drs_exec_model.sv ***
// Behavioural model of the decode and execute logic that faces the register map.
// Assumes one pclk domain; the bench calls its tasks from a single thread.
`timescale 1ns/1ps
module drs_exec_model (
  input wire logic pclk, // 20 MHz clock
  input drs_pkg::drs_ex_rsp_t ex_rsp, // Answer from the register map
  output drs_pkg::drs_ex_req_t ex_req, // Register access request
  output drs_pkg::drs_xfer_t xfer, // Transition pulses
  output logic ip_we, // Pointer update strobe
  output logic [63:0] ip_wdata // New pointer value
);
  initial begin
    ex_req = '0;
    xfer = '0;
    ip_we = 1'b0;
    ip_wdata = '0;
  end

  // ----------------------------------------------------------------
  // Register access, one cycle request, answer one cycle later
  // ----------------------------------------------------------------
  task automatic access(input logic wr, lg, fr, input logic [6:0] idx, input logic [5:0] lid,
                        input logic [63:0] wd, output logic [63:0] rd, output logic err, output logic ok);
    drs_pkg::drs_ex_req_t r;
    r = '{valid: 1'b1, write: wr, legacy: lg, is_fr: fr, idx: idx, legacy_id: lid, wdata: wd};
    @(posedge pclk);
    ex_req <= r;
    @(posedge pclk);
    // Idle data is inverted so a stale value can never pass for a fresh one.
    r.valid = 1'b0;
    r.wdata = ~wd;
    ex_req <= r;
    #1;
    ok = ex_rsp.valid === 1'b1;
    rd = ex_rsp.rdata;
    err = ex_rsp.err;
  endtask

  task automatic pulse(input drs_pkg::drs_xfer_t x);
    @(posedge pclk);
    xfer <= x;
    @(posedge pclk);
    xfer <= '0;
    #1;
  endtask

  task automatic set_ip(input logic [63:0] v);
    @(posedge pclk);
    ip_we <= 1'b1;
    ip_wdata <= v;
    @(posedge pclk);
    ip_we <= 1'b0;
    ip_wdata <= ~v;
    #1;
  endtask
endmodule

// *** verification/drs_top_tb.sv ***
// Self-checking bench for the dual instruction-set register map.
// Assumes drs_exec_model stands in for the execution logic; APB master is here.
`timescale 1ns/1ps
module drs_top_tb;
  localparam logic [63:0] DP = 64'h0000_8000_0000_0000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ip_we, legacy_active, xfer_refused, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [63:0] ip_wdata, ip;
  logic [1:0] legacy_mode;
  drs_pkg::drs_ex_req_t ex_req;
  drs_pkg::drs_ex_rsp_t ex_rsp;
  drs_pkg::drs_xfer_t xfer;
  int n_errors, compares;

  always #25 pclk = ~pclk;

  drs_top drs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ex_req(ex_req),
    .ex_rsp(ex_rsp), .xfer(xfer), .ip_we(ip_we), .ip_wdata(ip_wdata), .legacy_active(legacy_active),
    .legacy_mode(legacy_mode), .ip(ip), .xfer_refused(xfer_refused));
  drs_exec_model drs_exec_model_inst (.pclk(pclk), .ex_rsp(ex_rsp), .ex_req(ex_req), .xfer(xfer),
    .ip_we(ip_we), .ip_wdata(ip_wdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, ex, input string m);
    compares++;
    if (g !== ex) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, ex);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 8) begin
      n_errors++;
      wrap_up();
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic exa(input logic wr, lg, fr, input logic [6:0] idx, input logic [5:0] lid,
                     input logic [63:0] wd, ee, input logic er);
    logic [63:0] rd;
    logic err;
    logic ok;
    drs_exec_model_inst.access(wr, lg, fr, idx, lid, wd, rd, err, ok);
    chk(ok, 1'b1, "rsp valid");
    chk(err, er, "rsp err");
    if (!wr && !er) begin
      chk(rd, ee, "rsp data");
    end
  endtask

  task automatic xf(input logic j, i, t, input logic [1:0] m, input logic [63:0] tip, input logic act,
                    input logic [63:0] eip, input logic rf);
    drs_exec_model_inst.pulse('{jump_native: j, interrupt: i, to_legacy: t, target_mode: m, target_ip: tip});
    chk(legacy_active, act, "active");
    chk(ip, eip, "ip");
    chk(xfer_refused, rf, "refused");
    if (act) begin
      chk(legacy_mode, m, "mode");
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    n_errors = 0;
    compares = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(ip, 64'h0, "reset ip");
    chk(legacy_active, 1'b0, "reset mode");
    apb(0, drs_pkg::OFS_CTRL, 0);
    chk({e, d}, 33'h1, "ctrl reset");
    apb(0, 12'h020, 0);
    chk(e, 1'b1, "unmapped");
    $display("test reset done");
    apb(1, drs_pkg::OFS_INDEX, 32'h0000_0005);
    apb(1, drs_pkg::OFS_DATA_LO, 32'h89AB_CDEF);
    apb(1, drs_pkg::OFS_DATA_HI, 32'h0123_4567);
    exa(0, 0, 0, 7'd5, 0, 0, 64'h0123_4567_89AB_CDEF, 0);
    apb(1, drs_pkg::OFS_INDEX, 32'h0000_0103);
    apb(1, drs_pkg::OFS_DATA_LO, 32'h3FF0_0000);
    apb(1, drs_pkg::OFS_DATA_HI, 32'h4000_0000);
    apb(0, drs_pkg::OFS_DATA_HI, 0);
    chk(d, 32'h4000_0000, "fr3 hi");
    exa(1, 0, 0, 7'd0, 0, 64'h55, 0, 0);
    exa(0, 0, 0, 7'd0, 0, 0, 64'h0, 0);
    $display("test native access done");
    exa(1, 0, 0, 7'd27, 0, DP, 0, 0);
    exa(1, 0, 0, 7'd31, 0, DP, 0, 0);
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 2; k++) begin
        xf(0, 0, 1, m[1:0], 64'hFFFF_FFFF_0000_1000 + m, 1, 64'h1000 + m, 0);
        xf(k, !k, 0, m[1:0], 64'hABCD_0000_0000_0010, 0, 64'hABCD_0000_0000_0010, 0);
      end
    end
    $display("test transitions done");
    exa(1, 0, 0, 7'd8, 0, 64'h1111_2222_3333_4444, 0, 0);
    exa(1, 0, 0, 7'd16, 0, 64'h5555_6666_7777_8888, 0, 0);
    exa(1, 0, 0, 7'd12, 0, 64'h0, 0, 0);
    xf(0, 0, 1, 2'd2, 64'h2000, 1, 64'h2000, 0);
    exa(1, 1, 0, 0, 6'd0, 64'hDEAD_BEEF, 0, 0);
    exa(0, 1, 0, 0, 6'd0, 0, 64'hDEAD_BEEF, 0);
    exa(1, 1, 0, 0, 6'd4, 64'h7FF0, 0, 0);
    exa(1, 1, 0, 0, 6'd9, 64'hABCD, 0, 0);
    exa(1, 1, 0, 0, 6'd13, 64'h1357, 0, 0);
    exa(0, 1, 0, 0, 6'd13, 0, 64'h1357, 0);
    exa(1, 1, 0, 0, 6'd16, 64'h00CF_9300_0000_FFFF, 0, 0);
    exa(1, 1, 0, 0, 6'd24, 64'h8000_0000_0000_0001, 0, 0);
    exa(1, 1, 0, 0, 6'd33, 64'h0F0F_0F0F_F0F0_F0F0, 0, 0);
    exa(1, 0, 0, 7'd5, 0, 64'h0, 0, 1);
    exa(0, 0, 1, 7'd3, 0, 0, 0, 1);
    exa(1, 0, 0, 7'd20, 0, 64'h2020, 0, 0);
    exa(1, 0, 0, 7'd40, 0, 64'h4040, 0, 0);
    exa(1, 0, 1, 7'd6, 0, 64'h6060, 0, 0);
    exa(0, 1, 0, 0, 6'h30, 0, 0, 1);
    xf(0, 1, 0, 2'd2, 64'h3000, 0, 64'h3000, 0);
    exa(0, 0, 0, 7'd8, 0, 0, 64'h1111_2222_DEAD_BEEF, 0);
    exa(0, 0, 0, 7'd12, 0, 0, 64'h7FF0, 0);
    exa(0, 0, 0, 7'd16, 0, 0, 64'h5555_6666_ABCD_8888, 0);
    exa(0, 0, 0, 7'd24, 0, 0, 64'h00CF_9300_0000_FFFF, 0);
    exa(0, 0, 1, 7'd8, 0, 0, 64'h8000_0000_0000_0001, 0);
    exa(0, 0, 1, 7'd17, 0, 0, 64'h0F0F_0F0F_F0F0_F0F0, 0);
    exa(0, 0, 0, 7'd5, 0, 0, 64'h0123_4567_89AB_CDEF, 0);
    exa(0, 0, 1, 7'd3, 0, 0, 64'h4000_0000_3FF0_0000, 0);
    $display("test legacy mapping done");
    exa(1, 0, 0, 7'd27, 0, 64'h0, 0, 0);
    xf(0, 0, 1, 2'd1, 64'h4000, 0, 64'h3000, 1);
    apb(0, drs_pkg::OFS_STATUS, 0);
    chk(d[3], 1'b1, "check error");
    apb(1, drs_pkg::OFS_STATUS, 32'h0000_0008);
    apb(0, drs_pkg::OFS_STATUS, 0);
    chk(d[3], 1'b0, "check error cleared");
    exa(1, 0, 0, 7'd27, 0, DP, 0, 0);
    xf(0, 0, 1, 2'd1, 64'h4000, 1, 64'h4000, 0);
    apb(1, drs_pkg::OFS_CTRL, 0);
    xf(1, 0, 0, 2'd1, 64'h5000, 1, 64'h4000, 1);
    xf(0, 1, 0, 2'd1, 64'h6000, 0, 64'h6000, 0);
    drs_exec_model_inst.set_ip(64'h1234_5678_9ABC_DEF0);
    chk(ip, 64'h1234_5678_9ABC_DEF0, "ip update");
    apb(0, drs_pkg::OFS_IP_HI, 0);
    chk(d, 32'h1234_5678, "ip high read");
    apb(0, drs_pkg::OFS_IP_LO, 0);
    chk(d, 32'h9ABC_DEF0, "ip low read");
    $display("test refusals done");
    wrap_up();
  end
endmodule
